//--- spc_format_converter.sv
// spc_format_converter.sv: packet format converter with framing recovery
// What this block does
// RULE1: buffer input symbols, read out reordered
// RULE2: offer symbol once written and earlier sent
// RULE3: first beats of all outputs together
// RULE4: drop input ready before overwriting unsent data
// RULE5: keep accepting under back-pressure until full
// RULE6: drain memory under starvation, then drop valid
// RULE7: stalls on any side spread to all
// RULE8: fixed symbols per beat, layout per format
// RULE9: field names comma separated, case sensitive
// RULE10: repeat groups expand, plus group whole packet
// RULE11: nth output field from nth input field
// RULE12: field on one input only, outputs may copy
// RULE13: single mapping keeps equal field counts
// RULE14: multi-packet ratio fixed for all pairs
// RULE15: no multi-packet mapping for unknown length
// RULE16: flag start or end on wrong beat
// RULE17: flag missing start or end on due beat
// RULE18: error on all outputs until their end
// RULE19: stop each output, restart when all stopped
// RULE20: no input back-pressure during recovery
// RULE21: after restart discard until start flag
// RULE22: upstream errors never passed downstream
// RULE23: bench holds reset low, then high
// RULE24: stream signal set per interface
// RULE25: one to 32 symbols per beat
// RULE26: optional asynchronous clear besides sync reset
// RULE27: one rising edge, transfer on valid and ready
// RULE28: final beat empty gives unused lanes
module spc_format_converter
   import spc_pkg::*;
(
   input  wire logic                          clock,
   input  wire logic                          sys_rst,
   input  wire logic                          syncRstN,
   // RULE24 stream signals per interface
   input  wire logic                          inValid,
   output wire logic                          inReady,
   input  wire logic                          inSop,
   input  wire logic                          inEop,
   input  wire logic [EMPTY_W-1:0]            inEmpty,
   input  wire logic [IN_LANES*SYM_W-1:0]     inData,
   output wire logic                          out0Valid,
   input  wire logic                          out0Ready,
   output wire logic                          out0Sop,
   output wire logic                          out0Eop,
   output wire logic [EMPTY_W-1:0]            out0Empty,
   output wire logic [OUT0_LANES*SYM_W-1:0]   out0Data,
   output wire logic                          out0FrameError,
   output wire logic                          out1Valid,
   input  wire logic                          out1Ready,
   output wire logic                          out1Sop,
   output wire logic                          out1Eop,
   output wire logic [EMPTY_W-1:0]            out1Empty,
   output wire logic [OUT1_LANES*SYM_W-1:0]   out1Data,
   output wire logic                          out1FrameError,
   input  wire logic [AXI_ADDR_W-1:0]         s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output wire logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output wire logic                          s_axi_wready,
   output wire logic [1:0]                    s_axi_bresp,
   output wire logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0]         s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output wire logic                          s_axi_arready,
   output wire logic [31:0]                   s_axi_rdata,
   output wire logic [1:0]                    s_axi_rresp,
   output wire logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready
);

   spc_state_type               st_r;
   spc_state_type               st_nxt;
   logic                        asyncClr;
   logic [NOUT-1:0]             outReady;
   logic [NOUT-1:0]             xfer;
   logic [NOUT-1:0]             free;
   logic [NOUT-1:0]             avail;
   logic [NOUT-1:0]             endXfer;
   logic [NOUT-1:0][BEAT_W-1:0] nb;
   logic [NOUT-1:0]             nslot;
   logic                        sopGo;
   logic                        inAcc;
   logic                        frameChk;
   logic                        errDet;

   // asynchronous clear exists only when enabled
   assign asyncClr = sys_rst & ACLR_EN;
   assign outReady = {out1Ready, out0Ready};

   always_comb begin
      st_nxt = st_r;
      xfer = '0;
      free = '0;
      avail = '0;
      endXfer = '0;
      nb = '0;
      nslot = '0;

      // register slave: address and data taken in either order
      if (s_axi_awvalid && st_r.awReady) begin
         st_nxt.awHave = 1'b1;
         st_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wReady) begin
         st_nxt.wHave = 1'b1;
         st_nxt.wData = s_axi_wdata;
         st_nxt.wStrb = s_axi_wstrb;
      end
      if (st_r.awHave && st_r.wHave && !st_r.bVld) begin
         st_nxt.awHave = 1'b0;
         st_nxt.wHave = 1'b0;
         st_nxt.bVld = 1'b1;
         st_nxt.bResp = RESP_OKAY;
         case (st_r.awAddr)
            REG_CTRL: begin
               if (st_r.wStrb[0]) begin
                  st_nxt.ctrlDis = st_r.wData[CTRL_DIS_BIT];
               end
            end
            REG_STATUS: begin
               st_nxt.bResp = RESP_OKAY;
            end
            REG_ERRCNT: begin
               st_nxt.errCnt = '0;   // any write clears
            end
            default: begin
               st_nxt.bResp = RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bVld && s_axi_bready) begin
         st_nxt.bVld = 1'b0;
      end
      if (st_r.rVld && s_axi_rready) begin
         st_nxt.rVld = 1'b0;
      end
      if (s_axi_arvalid && st_r.arReady) begin
         st_nxt.rVld = 1'b1;
         st_nxt.rResp = RESP_OKAY;
         st_nxt.rData = '0;
         case (s_axi_araddr)
            REG_CTRL: begin
               st_nxt.rData[CTRL_DIS_BIT] = st_r.ctrlDis;
            end
            REG_STATUS: begin
               st_nxt.rData[STAT_MODE_LSB +: 2] = st_r.mode;
               st_nxt.rData[STAT_WRSLOT_BIT] = st_r.wrSlot;
               st_nxt.rData[STAT_STOP_LSB +: NOUT] = st_r.oStop;
               st_nxt.rData[STAT_ERR_LSB +: NOUT] = st_r.oErr;
            end
            REG_ERRCNT: begin
               st_nxt.rData[ERRCNT_W-1:0] = st_r.errCnt;
            end
            default: begin
               st_nxt.rResp = RESP_SLVERR;
            end
         endcase
      end

      // input side: beats accepted in run, or with a start flag while waiting, are checked against the position counter
      // RULE27: transfer on valid and ready
      inAcc = inValid && st_r.inReady;
      // RULE21: discard until start flag
      frameChk = inAcc && (st_r.mode == MODE_RUN || (st_r.mode == MODE_WAIT && inSop));
      // RULE16: misplaced start or end
      // RULE17: missing start or end
      errDet = frameChk && ((inSop != (st_r.wrBeat == '0))
                            || (inEop != (st_r.wrBeat == IN_LAST_BEAT)));
      // RULE1: spool symbols into memory
      if (frameChk && !errDet) begin
         for (int l = 0; l < IN_LANES; l++) begin
            st_nxt.mem[st_r.wrSlot][IDX_W'(int'(st_r.wrBeat) * IN_LANES + l)] =
               inData[l*SYM_W +: SYM_W];
         end
         st_nxt.slotSyms[st_r.wrSlot] = st_r.slotSyms[st_r.wrSlot] + IN_STEP;
         st_nxt.mode = MODE_RUN;
         if (st_r.wrBeat == IN_LAST_BEAT) begin
            st_nxt.wrBeat = '0;
            st_nxt.wrSlot = ~st_r.wrSlot;
         end else begin
            st_nxt.wrBeat = st_r.wrBeat + 1'b1;
         end
      end
      // RULE18: error raised on every output
      if (errDet) begin
         st_nxt.mode = MODE_RECOVER;
         st_nxt.oErr = '1;
         st_nxt.errCnt = st_nxt.errCnt + 1'b1;   // counts even against a clear
      end

      // output side: next beat index and slot after this cycle's handshakes
      for (int o = 0; o < NOUT; o++) begin
         xfer[o] = st_r.oVld[o] && outReady[o];
         free[o] = !st_r.oVld[o] || outReady[o];
         endXfer[o] = xfer[o] && st_r.oEop[o];
         nb[o] = endXfer[o] ? '0 : (xfer[o] ? st_r.oBeat[o] + 1'b1 : st_r.oBeat[o]);
         nslot[o] = endXfer[o] ? ~st_r.rdSlot[o] : st_r.rdSlot[o];
         // RULE2: beat ready once its symbols are written
         avail[o] = st_r.slotSyms[nslot[o]] >= OUT_NEED[o][nb[o]];
      end
      // RULE3: first beats released on all outputs together
      sopGo = (st_r.mode == MODE_RUN) && (&(free & avail))
              && (nb[0] == '0) && (nb[1] == '0);

      for (int o = 0; o < NOUT; o++) begin
         st_nxt.oBeat[o] = nb[o];
         st_nxt.rdSlot[o] = nslot[o];
         if (endXfer[o] && st_r.mode != MODE_RECOVER) begin
            st_nxt.slotDone[st_r.rdSlot[o]][o] = 1'b1;
         end
         // RULE6: valid drops when nothing is buffered
         if (free[o]) begin
            st_nxt.oVld[o] = 1'b0;
         end
         case (st_r.mode)
            MODE_RECOVER: begin
               // RULE19: ended outputs stay silent
               if (endXfer[o] || st_r.oStop[o]) begin
                  st_nxt.oStop[o] = 1'b1;
                  st_nxt.oErr[o] = 1'b0;
               end else if (free[o]) begin
                  // RULE18: error beat closes the packet
                  st_nxt.oVld[o] = 1'b1;
                  st_nxt.oSop[o] = (nb[o] == '0);
                  st_nxt.oEop[o] = 1'b1;
                  st_nxt.oEmpty[o] = '0;
                  for (int l = 0; l < OUT_MAXL; l++) begin
                     st_nxt.oData[o][l] = st_r.mem[nslot[o]][OUT_MAP[o][nb[o]][l]];
                  end
               end
            end
            MODE_RUN: begin
               // RULE7: output waits on input data and peers
               if (free[o] && avail[o] && (nb[o] != '0 || sopGo)) begin
                  st_nxt.oVld[o] = 1'b1;
                  st_nxt.oSop[o] = (nb[o] == '0);
                  // RULE8: beat layout from format table
                  st_nxt.oEop[o] = (nb[o] == OUT_LAST_BEAT[o]);
                  // RULE28: unused lanes on final beat
                  st_nxt.oEmpty[o] = (nb[o] == OUT_LAST_BEAT[o]) ? OUT_LAST_EMPTY[o] : '0;
                  // RULE11: nth field from nth input field
                  for (int l = 0; l < OUT_MAXL; l++) begin
                     st_nxt.oData[o][l] = st_r.mem[nslot[o]][OUT_MAP[o][nb[o]][l]];
                  end
               end
            end
            default: begin
               st_nxt.oStop[o] = 1'b0;
            end
         endcase
      end

      // a slot is released once every output has read it out
      for (int s = 0; s < SLOTS; s++) begin
         if (&st_nxt.slotDone[s]) begin
            st_nxt.slotSyms[s] = '0;
            st_nxt.slotDone[s] = '0;
         end
      end

      // RULE19: internal restart once all outputs stopped
      if (st_r.mode == MODE_RECOVER && (&st_r.oStop)) begin
         st_nxt.mode = MODE_WAIT;
         st_nxt.slotSyms = '0;
         st_nxt.slotDone = '0;
         st_nxt.wrSlot = 1'b0;
         st_nxt.wrBeat = '0;
         st_nxt.oStop = '0;
         st_nxt.oErr = '0;
         st_nxt.oVld = '0;
         st_nxt.rdSlot = '0;
         st_nxt.oBeat = '0;
      end

      // input ready
      case (st_nxt.mode)
         // RULE20: no back-pressure while recovering
         MODE_RECOVER: st_nxt.inReady = 1'b1;
         MODE_WAIT:    st_nxt.inReady = !st_nxt.ctrlDis;
         // RULE4: stop before overwriting unsent symbols
         // RULE5: keep accepting until slot full
         MODE_RUN: st_nxt.inReady = !st_nxt.ctrlDis
                                    && (st_nxt.slotSyms[st_nxt.wrSlot] != PKT_FULL);
         default:      st_nxt.inReady = 1'b0;
      endcase

      // channel readies follow the pending state
      st_nxt.awReady = !st_nxt.awHave && !st_nxt.bVld;
      st_nxt.wReady = !st_nxt.wHave && !st_nxt.bVld;
      st_nxt.arReady = !st_nxt.rVld;

      // RULE26: synchronous active-low reset
      if (!syncRstN) begin
         st_nxt = '0;
      end
   end

   // state register with asynchronous clear
   always_ff @(posedge clock or posedge asyncClr) begin
      if (asyncClr) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // RULE22: error outputs carry own framing errors only
   assign inReady        = st_r.inReady;
   assign out0Valid      = st_r.oVld[0];
   assign out0Sop        = st_r.oSop[0];
   assign out0Eop        = st_r.oEop[0];
   assign out0Empty      = st_r.oEmpty[0];
   assign out0Data       = st_r.oData[0][OUT0_LANES-1:0];
   assign out0FrameError = st_r.oErr[0];
   assign out1Valid      = st_r.oVld[1];
   assign out1Sop        = st_r.oSop[1];
   assign out1Eop        = st_r.oEop[1];
   assign out1Empty      = st_r.oEmpty[1];
   assign out1Data       = st_r.oData[1][OUT1_LANES-1:0];
   assign out1FrameError = st_r.oErr[1];
   assign s_axi_awready  = st_r.awReady;
   assign s_axi_wready   = st_r.wReady;
   assign s_axi_bresp    = st_r.bResp;
   assign s_axi_bvalid   = st_r.bVld;
   assign s_axi_arready  = st_r.arReady;
   assign s_axi_rdata    = st_r.rData;
   assign s_axi_rresp    = st_r.rResp;
   assign s_axi_rvalid   = st_r.rVld;

   // checks on the converter's own behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst || !syncRstN);

   sequence badStart;
      frameChk && st_r.mode == MODE_RUN && inSop && st_r.wrBeat != '0;
   endsequence
   sequence missedEnd;
      frameChk && !inSop && st_r.wrBeat == IN_LAST_BEAT && !inEop;
   endsequence
   sequence allStopped;
      st_r.mode == MODE_RECOVER && (&st_r.oStop);
   endsequence
   sequence heldBeat0;
      st_r.oVld[0] && !out0Ready;
   endsequence

   fullNoReady_a: assert property ( // RULE4
      st_r.mode == MODE_RUN && st_r.slotSyms[st_r.wrSlot] == PKT_FULL |-> !st_r.inReady)
      else $error("input ready high with write slot full");
   sopAlign_a: assert property ( // RULE3
      st_r.mode == MODE_RUN && $rose(st_r.oVld[0] && st_r.oSop[0])
      |-> st_r.oVld[1] && st_r.oSop[1])
      else $error("first beats not aligned across outputs");
   badStart_a: assert property ( // RULE16
      badStart |=> st_r.mode == MODE_RECOVER ##0 (&st_r.oErr))
      else $error("misplaced start flag not flagged");
   missedEnd_a: assert property ( // RULE17
      missedEnd |=> st_r.mode == MODE_RECOVER)
      else $error("missing end flag not flagged");
   errHold_a: assert property ( // RULE18
      st_r.oErr[0] && !(st_r.oVld[0] && out0Ready && st_r.oEop[0]) |=> st_r.oErr[0])
      else $error("error dropped before end of packet");
   stopQuiet_a: assert property ( // RULE19
      st_r.oStop[1] |-> !st_r.oVld[1])
      else $error("stopped output still offers data");
   restart_a: assert property ( // RULE19
      allStopped |=> st_r.mode == MODE_WAIT && st_r.oStop == '0 && st_r.oVld == '0)
      else $error("no restart after all outputs stopped");
   recoverReady_a: assert property ( // RULE20
      st_r.mode == MODE_RECOVER |-> st_r.inReady)
      else $error("inputs back-pressured during recovery");
   beatHold_a: assert property ( // RULE27
      heldBeat0 |=> st_r.oVld[0] && $stable(st_r.oData[0]) && $stable(st_r.oEop[0]))
      else $error("output beat changed while stalled");
   lastEmpty_a: assert property ( // RULE28
      st_r.oVld[1] && st_r.oEop[1] && !st_r.oErr[1] |-> st_r.oEmpty[1] == OUT_LAST_EMPTY[1])
      else $error("wrong empty count on final beat");

endmodule

//--- spc_pkg.sv
// spc_pkg.sv: constants, format tables and state type of the format converter
package spc_pkg;
   // RULE25 lanes within one to 32
   // symbol and interface geometry
   localparam int SYM_W      = 8;
   localparam int IN_LANES   = 3;
   localparam int IN_BEATS   = 4;
   localparam int PKT_SYMS   = 12;
   localparam int SLOTS      = 2;
   localparam int NOUT       = 2;
   localparam int OUT0_LANES = 4;
   localparam int OUT1_LANES = 2;
   localparam int OUT_MAXL   = 4;
   localparam int OUT_MAXB   = 3;
   localparam int EMPTY_W    = 5;
   localparam int IDX_W      = 4;
   localparam int CNT_W      = 4;
   localparam int BEAT_W     = 2;
   localparam int ERRCNT_W   = 16;
   localparam bit ACLR_EN    = 1'b1;

   // RULE9 RULE10 formats expanded to tables
   // input format (R,G,B)4 at three symbols per beat
   localparam logic [BEAT_W-1:0] IN_LAST_BEAT = 2'h3;
   localparam logic [CNT_W-1:0]  PKT_FULL     = 4'hc;
   localparam logic [CNT_W-1:0]  IN_STEP      = 4'h3;

   // output 0: (B,G,R)4 at four per beat, output 1: (G)4 at two per beat
   localparam logic [BEAT_W-1:0] OUT_LAST_BEAT [NOUT] = '{2'h2, 2'h1};
   // RULE12 RULE13 copies keep field counts
   // input symbol index feeding each output lane, lane 0 in the low bits
   localparam logic [IDX_W-1:0] OUT_MAP [NOUT][OUT_MAXB][OUT_MAXL] = '{
      '{'{4'h2, 4'h1, 4'h0, 4'h5}, '{4'h4, 4'h3, 4'h8, 4'h7}, '{4'h6, 4'hb, 4'ha, 4'h9}},
      '{'{4'h1, 4'h4, 4'h0, 4'h0}, '{4'h7, 4'ha, 4'h0, 4'h0}, '{4'h0, 4'h0, 4'h0, 4'h0}}};
   // RULE14 RULE15 one packet to one
   // symbols that must be in memory before each output beat may go
   localparam logic [CNT_W-1:0] OUT_NEED [NOUT][OUT_MAXB] = '{
      '{4'h6, 4'h9, 4'hc}, '{4'h5, 4'hb, 4'h0}};
   localparam logic [EMPTY_W-1:0] OUT_LAST_EMPTY [NOUT] = '{5'h00, 5'h00};

   // register map
   localparam int                AXI_ADDR_W      = 8;
   localparam logic [7:0]        REG_CTRL        = 8'h00;
   localparam logic [7:0]        REG_STATUS      = 8'h04;
   localparam logic [7:0]        REG_ERRCNT      = 8'h08;
   localparam int                CTRL_DIS_BIT    = 0;
   localparam int                STAT_MODE_LSB   = 0;
   localparam int                STAT_WRSLOT_BIT = 2;
   localparam int                STAT_STOP_LSB   = 4;
   localparam int                STAT_ERR_LSB    = 8;
   localparam logic [1:0]        RESP_OKAY       = 2'h0;
   localparam logic [1:0]        RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {
      MODE_WAIT    = 2'b00,
      MODE_RUN     = 2'b01,
      MODE_RECOVER = 2'b10
   } spc_mode_type;

   typedef struct packed {
      spc_mode_type                                   mode;
      logic [SLOTS-1:0][PKT_SYMS-1:0][SYM_W-1:0]      mem;
      logic [SLOTS-1:0][CNT_W-1:0]                    slotSyms;
      logic [SLOTS-1:0][NOUT-1:0]                     slotDone;
      logic                                           wrSlot;
      logic [BEAT_W-1:0]                              wrBeat;
      logic                                           inReady;
      logic [NOUT-1:0]                                oVld;
      logic [NOUT-1:0]                                oSop;
      logic [NOUT-1:0]                                oEop;
      logic [NOUT-1:0]                                oErr;
      logic [NOUT-1:0]                                oStop;
      logic [NOUT-1:0]                                rdSlot;
      logic [NOUT-1:0][BEAT_W-1:0]                    oBeat;
      logic [NOUT-1:0][OUT_MAXL-1:0][SYM_W-1:0]       oData;
      logic [NOUT-1:0][EMPTY_W-1:0]                   oEmpty;
      logic                                           ctrlDis;
      logic [ERRCNT_W-1:0]                            errCnt;
      logic                                           awHave;
      logic                                           wHave;
      logic [AXI_ADDR_W-1:0]                          awAddr;
      logic [31:0]                                    wData;
      logic [3:0]                                     wStrb;
      logic                                           awReady;
      logic                                           wReady;
      logic                                           bVld;
      logic [1:0]                                     bResp;
      logic                                           arReady;
      logic                                           rVld;
      logic [31:0]                                    rData;
      logic [1:0]                                     rResp;
   } spc_state_type;
endpackage

//--- spc_src_model.sv
// upstream packet sender for the converter input
module spc_src_model
   import spc_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      inReady,
   output logic                           inValid,
   output logic                           inSop,
   output logic                           inEop,
   output logic [IN_LANES*SYM_W-1:0]      inData
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle at time zero
   initial begin
      inValid = 1'b0;
      inSop = 1'b0;
      inEop = 1'b0;
      inData = '0;
   end

   // n packets, symbols up from s; bad 1 drops end, 2 adds start
   task automatic send(input logic [7:0] s, input int n, input int bad);
      logic [7:0] v;
      for (int p = 0; p < n; p++) begin
         for (int k = 0; k < IN_BEATS; k++) begin
            v = s + 8'(12 * p + 3 * k);
            inValid <= 1'b1;
            inSop <= (k == 0) || (bad == 2 && k == 2);
            inEop <= (k == IN_BEATS - 1) && bad != 1;
            inData <= {v + 8'h02, v + 8'h01, v};
            do @(posedge clock); while (inReady !== 1'b1);
         end
      end
      inValid <= 1'b0;
      // released lines stop showing the last value
      inData <= ~inData;
   endtask
endmodule

//--- testbench.sv
// self-checking bench for the format converter
module testbench
   import spc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
   logic                           clock, sys_rst, syncRstN, out0Ready, out1Ready;
   logic                           s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic                           s_axi_arvalid, s_axi_rready;
   logic [AXI_ADDR_W-1:0]          s_axi_awaddr, s_axi_araddr;
   logic [31:0]                    s_axi_wdata, rd;
   logic [3:0]                     s_axi_wstrb;
   logic [1:0]                     rsp;
   wire logic                      inValid, inReady, inSop, inEop, out0Valid, out0Sop;
   wire logic                      out0Eop, out0FrameError, out1Valid, out1Sop, out1Eop;
   wire logic                      out1FrameError, s_axi_awready, s_axi_wready;
   wire logic                      s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0]                s_axi_bresp, s_axi_rresp;
   wire logic [31:0]               s_axi_rdata;
   wire logic [IN_LANES*SYM_W-1:0] inData;
   wire logic [OUT0_LANES*SYM_W-1:0] out0Data;
   wire logic [OUT1_LANES*SYM_W-1:0] out1Data;
   wire logic [EMPTY_W-1:0]        out0Empty, out1Empty;
   int                             err_total, n_compared, cyc, skew, err0, err1, p0, p1;
   logic [7:0]                     q0[$], q1[$];

   spc_format_converter DUT (
      .clock, .sys_rst, .syncRstN, .inValid, .inReady, .inSop, .inEop, .inEmpty(5'h00),
      .inData, .out0Valid, .out0Ready, .out0Sop, .out0Eop, .out0Empty, .out0Data,
      .out0FrameError, .out1Valid, .out1Ready, .out1Sop, .out1Eop, .out1Empty, .out1Data,
      .out1FrameError, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   spc_src_model src (.clock, .inReady, .inValid, .inSop, .inEop, .inData);

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // verdict and end of run
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   // collect taken output symbols, error beats and start skew
   always @(posedge clock) begin
      if (out0Valid && out0Ready && out0FrameError) err0++;
      else if (out0Valid && out0Ready) begin
         for (int l = 0; l < OUT0_LANES; l++) q0.push_back(out0Data[8*l +: 8]);
         if (out0Eop) `CHK("empty0", 5'h00, out0Empty)
      end
      if (out1Valid && out1Ready && out1FrameError) err1++;
      else if (out1Valid && out1Ready) begin
         for (int l = 0; l < OUT1_LANES; l++) q1.push_back(out1Data[8*l +: 8]);
         if (out1Eop) `CHK("empty1", 5'h00, out1Empty)
      end
      if (out0Ready && out1Ready && !out0FrameError && !out1FrameError
          && (out0Valid && out0Sop && !p0) !== (out1Valid && out1Sop && !p1)) skew++;
      p0 <= out0Valid && out0Sop;
      p1 <= out1Valid && out1Sop;
   end

   // one AXI4-Lite write, address and data offered together
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // one AXI4-Lite read into rd and rsp
   task automatic axiRd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // compare n reordered packets against the symbols sent from s
   task automatic chkPkts(input logic [7:0] s, input int n);
      logic [7:0] x;
      for (int t = 0; t < 600 && q0.size() + q1.size() < 16 * n; t++) @(posedge clock);
      `CHK("count0", 12 * n, q0.size())
      for (int j = 0; j < 12 * n; j++) begin
         x = s + 8'(12 * (j / 12) + 3 * ((j % 12) / 3) + 2 - j % 3);
         `CHK("out0 sym", x, q0[j])
      end
      for (int j = 0; j < 4 * n; j++) begin
         x = s + 8'(12 * (j / 4) + 3 * (j % 4) + 1);
         `CHK("out1 sym", x, q1[j])
      end
      q0.delete();
      q1.delete();
   endtask

   // main sequence
   initial begin
      {sys_rst, out0Ready, out1Ready, syncRstN} = 4'he;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hf};
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      syncRstN <= 1'b1;
      axiRd(REG_STATUS);
      `CHK("status reset", 32'h0, rd)
      axiRd(8'h0c);
      `CHK("unmapped resp", RESP_SLVERR, rsp)
      `CHK("unmapped data", 32'h0, rd)
      src.send(8'h10, 1, 1'b0);
      chkPkts(8'h10, 1);
      @(posedge clock);
      `CHK("drained", 1'b0, out0Valid)
      axiWr(REG_CTRL, 32'h1);
      `CHK("wr resp", RESP_OKAY, rsp)
      axiRd(REG_CTRL);
      `CHK("ctrl", 32'h1, rd)
      `CHK("ctrl stall", 1'b0, inReady)
      axiWr(REG_CTRL, 32'h0);
      out0Ready <= 1'b0;
      fork
         src.send(8'h20, 3, 1'b0);
         begin
            for (int t = 0; t < 200 && inReady !== 1'b0; t++) @(posedge clock);
            repeat (4) @(posedge clock);
            `CHK("full stall", 1'b0, inReady)
            `CHK("starved out1", 1'b0, out1Valid)
            out0Ready <= 1'b1;
         end
      join
      chkPkts(8'h20, 3);
      // missing end, then misplaced start
      for (int b = 1; b < 3; b++) begin
         src.send(8'h50, 1, b);
         for (int t = 0; t < 20; t++) begin
            axiRd(REG_STATUS);
            if (rd[1:0] === 2'h0) break;
         end
      end
      `CHK("err out0", 1'b1, err0 != 0)
      `CHK("err out1", 1'b1, err1 != 0)
      axiRd(REG_ERRCNT);
      `CHK("err count", 32'h2, rd)
      q0.delete();
      q1.delete();
      src.send(8'h60, 1, 1'b0);
      chkPkts(8'h60, 1);
      `CHK("sop skew", 0, skew)
      conclude();
   end
endmodule
